// *** hw/mux_bus_pkg.sv ***
// Purpose: Shared constants and types for the multiplexed bus interface
// Assumes: One 40 MHz clock, synchronous active-high reset
// Notes: Word layout of queued stores travels as a packed struct
package mux_bus_pkg;
    localparam int BUS_W = 32;
    localparam int WB_DEPTH = 4;
    localparam int RB_DEPTH = 4;
    localparam int BURST_LEN = 4;
    localparam int SINGLE_LEN = 1;
    localparam int LANE_W = 4;
    localparam logic [1:0] IDX_RESET = 2'h0;
    localparam logic [BUS_W-1:0] AD_RESET = 32'h00000000;

    typedef struct packed {
        logic [31:4] addr;
        logic [1:0] word;
        logic [3:0] lanes;
        logic [31:0] data;
    } wr_entry_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_ADDR,
        ST_RD_DATA,
        ST_WR_ADDR,
        ST_WR_DATA,
        ST_TURN
    } bus_state_t;
endpackage

// *** hw/mux_bus_unit.sv ***
// Purpose: Processor-side unit driving the shared address/data bus
// Assumes: Bus inputs synchronous to sys_clk; partner is a wait-state controller
// Notes: Writes drain before a pending read so reads never pass stores
//
// Summary of operation
// - One shared 32-bit bus carries the address then the data of each transfer.
// - A four-word read buffer and a four-word write buffer decouple the core.
// - A read starts on a cache miss or an uncachable reference.
// - A read fills one word in single mode and four words in burst mode.
// - Each store taken while the write buffer is not full updates the data cache and is also queued as a bus write.
// - The core keeps running while up to four queued writes drain.
// - A burst output is driven in burst reads and word-index outputs count the words.
// - In burst reads the acknowledge input may restart the core pipeline.
// - The latch strobe can drive a transparent latch, high passes, low holds.
// - The byte-lane selects sit on the low four bus bits in the address phase.
// - The word index steps 0 to 3 in a burst, one step per read strobe.
// - A new address may follow soon after read data is sampled.
`timescale 1ns/1ps
module mux_bus_unit
    import mux_bus_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic rd_req,
    input wire logic cache_miss,
    input wire logic uncachable,
    input wire logic rd_burst,
    input wire logic [31:2] rd_addr,
    input wire logic st_req,
    input wire wr_entry_t st_entry,
    output logic dcache_wr,
    output logic st_full,
    output logic core_stall,
    output logic restart,
    output logic rd_valid,
    output logic [31:0] rd_data,
    output logic [1:0] rd_word,
    input wire logic [31:0] ad_in,
    output logic [31:0] ad_out,
    output logic ad_oe,
    output logic ale,
    output logic rd_n,
    output logic wr_n,
    output logic burst,
    output logic [1:0] word_index,
    input wire logic read_word_strobe_n,
    input wire logic ack_n
);
    // Pointers and counters are sized for these depths only
    if (WB_DEPTH != 4 || RB_DEPTH < BURST_LEN || BUS_W != 32) begin : g_size_check
        $error("mux_bus_unit: unsupported buffer or bus size");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    bus_state_t state_ff;
    wr_entry_t wbuf_ff [WB_DEPTH];
    logic [1:0] wr_ptr_ff, rd_ptr_ff;
    logic [2:0] wb_cnt_ff;
    logic [31:0] rbuf_ff [RB_DEPTH];
    logic [2:0] fill_ff, len_ff, drain_ff;
    logic [1:0] drain_idx_ff;
    logic rd_pend_ff, pend_burst_ff, restarted_ff, core_stall_ff, st_full_ff;
    logic [31:2] pend_addr_ff;
    logic [31:0] ad_out_ff, rd_data_ff;
    logic ad_oe_ff, ale_ff, rd_n_ff, wr_n_ff, burst_ff, dcache_wr_ff, restart_ff, rd_valid_ff;
    logic [1:0] word_index_ff, rd_word_ff;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire rd_start = rd_req && (cache_miss || uncachable);
    wire wb_full = (wb_cnt_ff == 3'(WB_DEPTH));
    wire push = st_req && !wb_full;
    wire word_take = (state_ff == ST_RD_DATA) && !read_word_strobe_n;
    wire last_word = word_take && (fill_ff == len_ff - 3'h1);
    wire wr_done = (state_ff == ST_WR_DATA) && !ack_n;
    wire pop = wr_done;
    wire go_write = (state_ff == ST_IDLE) && (wb_cnt_ff != 3'h0);
    wire go_read = (state_ff == ST_IDLE) && (wb_cnt_ff == 3'h0) && rd_pend_ff;
    wire burst_ack = (state_ff == ST_RD_DATA) && burst_ff && !ack_n && !restarted_ff;
    wire wr_entry_t head = wbuf_ff[rd_ptr_ff];
    wire [2:0] nxt_wb_cnt = wb_cnt_ff + {2'h0, push} - {2'h0, pop};
    wire nxt_pend = (rd_pend_ff && !go_read) || rd_start;
    wire nxt_stall = nxt_pend || (state_ff == ST_RD_ADDR) || (state_ff == ST_RD_DATA)
                     || (drain_ff > 3'h1) || last_word;

    // ----------------------------------------------------------------
    // Write buffer: stores queue while the core runs on
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_ptr_ff <= 2'h0;
            rd_ptr_ff <= 2'h0;
            wb_cnt_ff <= 3'h0;
            dcache_wr_ff <= 1'b0;
            st_full_ff <= 1'b0;
        end else begin
            if (push) begin
                wbuf_ff[wr_ptr_ff] <= st_entry;
                wr_ptr_ff <= wr_ptr_ff + 2'h1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 2'h1;
            end
            wb_cnt_ff <= nxt_wb_cnt;
            dcache_wr_ff <= push;
            st_full_ff <= (nxt_wb_cnt == 3'(WB_DEPTH));
        end
    end

    // Pending read request; stall holds the core until its words are handed back
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_pend_ff <= 1'b0;
            pend_burst_ff <= 1'b0;
            pend_addr_ff <= 30'h00000000;
            core_stall_ff <= 1'b0;
        end else begin
            rd_pend_ff <= nxt_pend;
            core_stall_ff <= nxt_stall;
            if (rd_start) begin
                pend_burst_ff <= rd_burst;
                pend_addr_ff <= rd_addr;
            end
        end
    end

    // ----------------------------------------------------------------
    // Bus sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            ad_out_ff <= AD_RESET;
            ad_oe_ff <= 1'b0;
            ale_ff <= 1'b0;
            rd_n_ff <= 1'b1;
            wr_n_ff <= 1'b1;
            burst_ff <= 1'b0;
            word_index_ff <= IDX_RESET;
            fill_ff <= 3'h0;
            len_ff <= 3'(SINGLE_LEN);
            restarted_ff <= 1'b0;
            restart_ff <= 1'b0;
        end else begin
            restart_ff <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    if (go_write) begin
                        // Address with lanes on the low bits, strobe high to open latch
                        ad_out_ff <= {head.addr, head.lanes};
                        word_index_ff <= head.word;
                        ad_oe_ff <= 1'b1;
                        ale_ff <= 1'b1;
                        state_ff <= ST_WR_ADDR;
                    end else if (go_read) begin
                        ad_out_ff <= {pend_addr_ff[31:4], 4'hF};
                        word_index_ff <= pend_burst_ff ? IDX_RESET : pend_addr_ff[3:2];
                        ad_oe_ff <= 1'b1;
                        ale_ff <= 1'b1;
                        burst_ff <= pend_burst_ff;
                        len_ff <= pend_burst_ff ? 3'(BURST_LEN) : 3'(SINGLE_LEN);
                        fill_ff <= 3'h0;
                        restarted_ff <= 1'b0;
                        state_ff <= ST_RD_ADDR;
                    end
                end
                ST_RD_ADDR: begin
                    // Latch closes, bus released before memory may drive it
                    ale_ff <= 1'b0;
                    ad_oe_ff <= 1'b0;
                    rd_n_ff <= 1'b0;
                    state_ff <= ST_RD_DATA;
                end
                ST_RD_DATA: begin
                    if (burst_ack) begin
                        restart_ff <= 1'b1;
                        restarted_ff <= 1'b1;
                    end
                    if (word_take) begin
                        fill_ff <= fill_ff + 3'h1;
                        if (burst_ff) begin
                            word_index_ff <= word_index_ff + 2'h1;
                        end
                    end
                    if (last_word) begin
                        rd_n_ff <= 1'b1;
                        burst_ff <= 1'b0;
                        restart_ff <= !restarted_ff || burst_ack;
                        state_ff <= ST_TURN;
                    end
                end
                ST_WR_ADDR: begin
                    ale_ff <= 1'b0;
                    ad_out_ff <= head.data;
                    wr_n_ff <= 1'b0;
                    state_ff <= ST_WR_DATA;
                end
                ST_WR_DATA: begin
                    // Held as long as memory needs
                    if (wr_done) begin
                        wr_n_ff <= 1'b1;
                        ad_oe_ff <= 1'b0;
                        state_ff <= ST_TURN;
                    end
                end
                ST_TURN: begin
                    // One idle cycle: single-edge logic cannot start half a cycle early
                    state_ff <= ST_IDLE;
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Read buffer: filled by strobes, then handed to the core word by word
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            drain_ff <= 3'h0;
            drain_idx_ff <= 2'h0;
            rd_valid_ff <= 1'b0;
            rd_data_ff <= AD_RESET;
            rd_word_ff <= 2'h0;
        end else begin
            if (word_take) begin
                rbuf_ff[fill_ff[1:0]] <= ad_in;
            end
            rd_valid_ff <= drain_ff != 3'h0;
            if (last_word) begin
                drain_ff <= len_ff;
                drain_idx_ff <= 2'h0;
            end else if (drain_ff != 3'h0) begin
                rd_data_ff <= rbuf_ff[drain_idx_ff];
                rd_word_ff <= drain_idx_ff;
                drain_idx_ff <= drain_idx_ff + 2'h1;
                drain_ff <= drain_ff - 3'h1;
            end
        end
    end

    // Every output comes straight from its flip-flop
    assign {dcache_wr, st_full, core_stall, restart, rd_valid, ad_oe, ale, rd_n, wr_n, burst} =
        {dcache_wr_ff, st_full_ff, core_stall_ff, restart_ff, rd_valid_ff, ad_oe_ff, ale_ff,
         rd_n_ff, wr_n_ff, burst_ff};
    assign {rd_data, rd_word, ad_out, word_index} =
        {rd_data_ff, rd_word_ff, ad_out_ff, word_index_ff};

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    AST_ALE_DRIVES: assert property (ale_ff |-> ad_oe_ff ##1 !ale_ff)
        else $error("strobe without driven address");
    AST_RD_RELEASE: assert property (!rd_n_ff |-> !ad_oe_ff)
        else $error("bus driven during read data");
    AST_WB_BOUND: assert property (wb_cnt_ff <= 3'(WB_DEPTH))
        else $error("write buffer overrun");
    AST_RD_START: assert property (rd_start |=> rd_pend_ff && core_stall_ff)
        else $error("read miss not taken");
    AST_FILL_END: assert property (last_word |=> state_ff == ST_TURN && rd_n_ff
        && drain_ff == $past(len_ff))
        else $error("read fill length wrong");
    AST_WR_THROUGH: assert property (push |=> dcache_wr_ff && wb_cnt_ff != 3'h0)
        else $error("store not written through");
    AST_WR_HOLD: assert property (state_ff == ST_WR_DATA && ack_n |=>
        state_ff == ST_WR_DATA && !wr_n_ff && ad_oe_ff)
        else $error("write dropped before acknowledge");
    AST_IDX_STEP: assert property (word_take && burst_ff && !last_word |=>
        word_index_ff == $past(word_index_ff) + 2'h1)
        else $error("word index did not step");
    AST_BURST_OUT: assert property (state_ff == ST_RD_DATA && len_ff == 3'(BURST_LEN)
        |-> burst_ff)
        else $error("burst output missing");
    AST_RESTART: assert property (burst_ack |=> restart_ff ##1 !restart_ff)
        else $error("no restart on acknowledge");
    AST_TURN_GAP: assert property (state_ff == ST_TURN |-> !ad_oe_ff ##1 !ale_ff)
        else $error("address driven in turnaround");

    COV_BURST: cover property (go_read && pend_burst_ff ##[1:50] last_word);
    COV_SINGLE: cover property (go_read && !pend_burst_ff ##[1:50] last_word);
    COV_WRITE: cover property (go_write ##[1:50] wr_done);
    COV_FULL: cover property (wb_full && st_req);
endmodule

// *** test/mem_partner.sv ***
// Purpose: Wait-state controller and address latch model facing the bus unit
// Assumes: Reacts on the falling edge; wait states and early ack set by the bench
// Notes: Released bus lines toggle every cycle so stale data never looks valid
`timescale 1ns/1ps
module mem_partner
    import mux_bus_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [31:0] ad_out,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic burst,
    input wire logic [1:0] word_index,
    input wire logic [3:0] wait_cyc,
    input wire logic ack_early,
    output logic [31:0] ad_in,
    output logic read_word_strobe_n,
    output logic ack_n,
    output logic [31:0] lat_addr,
    output logic [31:0] wr_data,
    output logic [7:0] wr_cnt
);
    logic [3:0] cnt;
    logic [2:0] words;
    wire [2:0] limit = burst ? 3'h4 : 3'h1;
    // A word is due once the wait states have passed; slow memories may wait up to 15 cycles, as set by wait_cyc
    wire word_due = !rd_n && (words < limit) && (cnt >= wait_cyc);
    wire ack_due = rd_n && !wr_n && (cnt >= wait_cyc);

    // ------------------------------------------------------------
    // Response engine
    // ------------------------------------------------------------
    // One decision per cycle on the falling edge, so lines are settled when the unit samples
    always @(negedge sys_clk) begin
        if (rst) begin
            ad_in <= 32'h00000000;
            read_word_strobe_n <= 1'b1;
            ack_n <= 1'b1;
            lat_addr <= 32'h00000000;
            wr_data <= 32'h00000000;
            wr_cnt <= 8'h00;
            cnt <= 4'h0;
            words <= 3'h0;
        end else begin
            // Transparent while the strobe is high, holds once it drops
            if (ale) begin
                lat_addr <= ad_out;
            end
            read_word_strobe_n <= !word_due;
            ack_n <= !(ack_due || (word_due && ack_early && burst && words == 3'h0));
            if (word_due) begin
                ad_in <= {lat_addr[31:4], word_index, 2'h0} ^ 32'h5A5A0000;
            end else begin
                ad_in <= ~ad_in;
            end
            if (ack_due) begin
                wr_data <= ad_out;
                wr_cnt <= wr_cnt + 8'h01;
            end
            if (rd_n && wr_n) begin
                cnt <= 4'h0;
                words <= 3'h0;
            end else if (word_due || ack_due) begin
                cnt <= 4'h0;
                words <= words + {2'h0, word_due};
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule

// *** test/cpu_mux_bus_interface_bench.sv ***
// Purpose: Self-checking bench for the multiplexed bus unit
// Assumes: Inputs change on the falling edge; partner model answers the bus
// Notes: Read data pattern mirrors the partner so words and order are checked
`timescale 1ns/1ps
module cpu_mux_bus_interface_bench
    import mux_bus_pkg::*;
;
    logic sys_clk = 1'b0, rst, rd_req, cache_miss, uncachable, rd_burst, st_req, ack_early;
    logic [31:2] rd_addr;
    wr_entry_t st_entry;
    logic dcache_wr, st_full, core_stall, restart, rd_valid, ad_oe, ale, rd_n, wr_n, burst;
    logic [31:0] rd_data, ad_in, ad_out, lat_addr, wr_data;
    logic [1:0] rd_word, word_index;
    logic read_word_strobe_n, ack_n;
    logic [3:0] wait_cyc;
    logic [7:0] wr_cnt;
    int bad_count = 0, n_checks = 0;

    always #12.5 sys_clk = ~sys_clk;

    mux_bus_unit dut_u (.sys_clk, .rst, .rd_req, .cache_miss, .uncachable, .rd_burst, .rd_addr,
        .st_req, .st_entry, .dcache_wr, .st_full, .core_stall, .restart, .rd_valid, .rd_data,
        .rd_word, .ad_in, .ad_out, .ad_oe, .ale, .rd_n, .wr_n, .burst, .word_index,
        .read_word_strobe_n, .ack_n);
    mem_partner mem_u (.sys_clk, .rst, .ad_out, .ale, .rd_n, .wr_n, .burst, .word_index,
        .wait_cyc, .ack_early, .ad_in, .read_word_strobe_n, .ack_n, .lat_addr, .wr_data, .wr_cnt);

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
            bad_count++;
        end
    endtask

    task automatic end_sim();
        if (bad_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Read request, then collect words and judge count, order, data and strobes
    task automatic t_read(input logic bst, input logic mis, input logic unc,
                          input logic [31:2] a, input logic [3:0] w, input logic ak);
        int n, rs, bs, st, want;
        n = 0;
        st = 0;
        rs = 0;
        bs = 0;
        want = (mis || unc) ? (bst ? BURST_LEN : SINGLE_LEN) : 0;
        wait_cyc = w;
        ack_early = ak;
        {rd_req, cache_miss, uncachable, rd_burst, rd_addr} = {1'b1, mis, unc, bst, a};
        @(negedge sys_clk);
        {rd_req, cache_miss, uncachable} = 3'h0;
        for (int i = 0; i < 120 && n < 4; i++) begin
            @(negedge sys_clk);
            if (burst === 1'b1) bs++;
            if (restart === 1'b1) rs++;
            if (core_stall === 1'b1) st++;
            if (rd_valid === 1'b1) begin
                check("rd_data", rd_data,
                    {a[31:4], bst ? 2'(n) : a[3:2], 2'h0} ^ 32'h5A5A0000);
                check("rd_word", {30'h0, rd_word}, 32'(n));
                n++;
            end
        end
        check("words", 32'(n), 32'(want));
        if (want != 0) check("addr_phase", lat_addr, {a[31:4], 4'hF});
        check("burst_seen", 32'(bs != 0), 32'(bst && want != 0));
        if (bst && want != 0) check("restart", 32'(rs), 32'h1);
        check("stall_seen", 32'(st != 0), 32'(want != 0));
        check("rd_idle", {29'h0, ad_oe, rd_n, burst}, 32'h2);
        repeat (3) @(negedge sys_clk);
    endtask

    // Five back-to-back stores into a four-word buffer while memory stalls
    task automatic t_stores();
        int acc, full, stl;
        logic [7:0] base;
        acc = 0;
        full = 0;
        stl = 0;
        base = wr_cnt;
        wait_cyc = 4'h6;
        for (int i = 0; i < 90; i++) begin
            st_req = (i < 5);
            st_entry = '{28'h1234560 + 28'(i), 2'(i), 4'h1 << i[1:0], 32'hC0DE0000 + 32'(i)};
            @(negedge sys_clk);
            if (dcache_wr === 1'b1) acc++;
            if (st_full === 1'b1) full++;
            if (core_stall !== 1'b0) stl++;
        end
        check("accepted", 32'(acc), 32'(WB_DEPTH));
        check("full_seen", 32'(full != 0), 32'h1);
        check("stall", 32'(stl), 32'h0);
        check("drained", 32'(wr_cnt - base), 32'h4);
        check("wr_data", wr_data, 32'hC0DE0003);
        check("wr_addr", lat_addr, 32'h12345638);
        check("wr_index", {30'h0, word_index}, 32'h3);
        check("full_clear", {31'h0, st_full}, 32'h0);
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        {rst, rd_req, cache_miss, uncachable, rd_burst, st_req, ack_early} = 7'h40;
        rd_addr = 30'h0;
        st_entry = '0;
        wait_cyc = 4'h0;
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        @(negedge sys_clk);
        check("idle", {25'h0, ad_oe, ale, rd_n, wr_n, burst, word_index}, 32'h18);
        t_read(1'b1, 1'b1, 1'b0, 30'h0C48D159, 4'h0, 1'b0);
        t_read(1'b1, 1'b0, 1'b1, 30'h2AAAAAA7, 4'h3, 1'b1);
        t_read(1'b0, 1'b1, 1'b0, 30'h11111112, 4'h2, 1'b0);
        t_read(1'b1, 1'b0, 1'b0, 30'h01234567, 4'h0, 1'b0);
        t_stores();
        end_sim();
    end

    initial begin
        repeat (5000) @(posedge sys_clk);
        bad_count++;
        end_sim();
    end
endmodule
